// ### rtl/bkm_matcher.sv
// Bus breakpoint matcher top: AHB-Lite register slave plus the per-cycle match decision.
// Assumes monitored cycles arrive as one-cycle strobes synchronous to hclk.
//
// Summary of operation
// - 32-bit writable target; used only while valid.
// - Control clears at reset; bits 31-20 reserved.
// - Ack support: bus error on breakpoint-ack cycles, else no action.
// - Source 0 internal, 1 external minus address bits 1:0.
// - External source implies size mask.
// - External break goes out; internal DMA breaks inside.
// - Bursts compare the first beat only.
// - Direction 00 read, 01 write, 10 both, 11 reserved.
// - Size mask clear: sizes must be equal.
// - Size mask set: accessed bytes overlap the target; a target at 01 also hits any access at 10 or 11.
// - Exact mode: address and size both equal.
// - Size compare only with block mask 00.
// - Size 00 long, 01 byte, 10 word, 11 three bytes.
// - Overlap cases for targets at 00 and 01.
// - Overlap cases for targets at 10 and 11.
// - No break unless valid.
// - Block mask drops none, bits 10-0, 12-0 or 14-0.
// - Negate with a mask matches outside the block.
// - Nine space bits suppress spaces; bit 8 covers DMA.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module bkm_matcher
(
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [7:0]           haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic                 hready,
   input  wire logic [31:0]          hwdata,
   output logic      [31:0]          hrdata,
   output wire logic                 hreadyout,
   output wire logic                 hresp,
   // Internal module bus cycle monitor
   input  wire logic                 int_cycle_valid,
   input  wire logic [31:0]          int_addr,
   input  wire logic                 int_read,
   input  wire logic [1:0]           int_size,
   input  wire logic [3:0]           int_function_code,
   input  wire logic                 int_dma_internal,
   input  wire logic                 int_break_signal_ack_cycle,
   // External bus cycle monitor
   input  wire logic                 ext_cycle_valid,
   input  wire logic [31:0]          ext_addr,
   input  wire logic                 ext_read,
   input  wire logic [1:0]           ext_size,
   input  wire logic [3:0]           ext_function_code,
   input  wire logic                 ext_burst_beat,
   // Outputs
   output logic                      break_signal,
   output logic                      break_signal_out,
   output logic                      bus_error
);
   import bkm_pkg::*;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [31:0] target_ff;
   logic [31:0] control_ff;
   logic [7:0]  wr_addr_ff;
   logic        wr_pend_ff;
   logic [7:0]  status_ff;
   logic [7:0]  nxt_status;
   logic [31:0] nxt_rdata;

   // ****************************************************************
   // AHB-Lite slave decode
   // ****************************************************************
   // Zero wait states: writes land after the data phase, reads come from flops.
   wire logic       bus_take;
   wire logic       take_write;
   wire logic       take_read;
   wire logic       sel_target;
   wire logic       sel_control;
   wire logic       sel_status;
   wire logic       wr_target;
   wire logic       wr_control;

   assign bus_take    = hsel && hready && htrans[1];
   assign take_write  = bus_take && hwrite;
   assign take_read   = bus_take && !hwrite;
   assign sel_target  = (haddr == BKM_ADDR_TARGET);
   assign sel_control = (haddr == BKM_ADDR_CONTROL);
   assign sel_status  = (haddr == BKM_ADDR_STATUS);
   assign wr_target   = wr_pend_ff && (wr_addr_ff == BKM_ADDR_TARGET);
   assign wr_control  = wr_pend_ff && (wr_addr_ff == BKM_ADDR_CONTROL);
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;

   // Unmapped addresses read as zero and ignore writes.
   assign nxt_rdata = !take_read   ? hrdata :
                      sel_target   ? target_ff :
                      sel_control  ? control_ff :
                      sel_status   ? {24'h00_0000, status_ff} : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata     <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_ff <= take_write;
         wr_addr_ff <= haddr;
         hrdata     <= nxt_rdata;
      end
   end

   // Target contents are don't-care until valid is set; a zero reset keeps simulation clean.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         target_ff  <= BKM_TARGET_RESET;
         control_ff <= BKM_CTRL_RESET;
      end
      else
      begin
         if (wr_target)
         begin
            target_ff <= hwdata;
         end
         if (wr_control)
         begin
            control_ff <= hwdata & BKM_CTRL_WMASK;
         end
      end
   end

   // ****************************************************************
   // Control fields
   // ****************************************************************
   wire logic       ctl_valid;
   wire logic [8:0] space_exclude_bits;
   wire logic [1:0] block_mask_select;
   wire logic       outside_block_match;
   wire logic [1:0] target_size_code;
   wire logic       size_compare_mask;
   wire logic [1:0] direction_select;
   wire logic       compare_source_select;
   wire logic       ack_cycle_support;

   assign ctl_valid             = control_ff[BKM_F_VALID];
   assign space_exclude_bits    = control_ff[BKM_F_SPACE_H:BKM_F_SPACE_L];
   assign block_mask_select     = control_ff[BKM_F_MASK_H:BKM_F_MASK_L];
   assign outside_block_match   = control_ff[BKM_F_NEG];
   assign target_size_code      = control_ff[BKM_F_SIZE_H:BKM_F_SIZE_L];
   assign size_compare_mask     = control_ff[BKM_F_SIZE_COMPARE_MASK];
   assign direction_select      = control_ff[BKM_F_DIR_H:BKM_F_DIR_L];
   assign compare_source_select = control_ff[BKM_F_SRC];
   assign ack_cycle_support     = control_ff[BKM_F_ACK];

   // ****************************************************************
   // Cycle source selection
   // ****************************************************************
   wire logic        cyc_valid;
   wire logic [31:0] cyc_addr;
   wire logic        cyc_read;
   wire logic [1:0]  cyc_size;
   wire logic [3:0]  cyc_fc;
   wire logic [1:0]  low_address_bits;

   // Follow-on burst beats are dropped.
   assign cyc_valid = compare_source_select ? (ext_cycle_valid && !ext_burst_beat) : int_cycle_valid;
   assign cyc_addr  = compare_source_select ? ext_addr : int_addr;
   assign cyc_read  = compare_source_select ? ext_read : int_read;
   assign cyc_size  = compare_source_select ? ext_size : int_size;
   assign cyc_fc    = compare_source_select ? ext_function_code : int_function_code;
   assign low_address_bits = cyc_addr[1:0];

   // ****************************************************************
   // Address, block and negate
   // ****************************************************************
   wire logic [31:0] block_amask;
   wire logic [31:0] addr_amask;
   wire logic        block_equal;
   wire logic        block_masked;
   wire logic        addr_ok;

   assign block_amask = (block_mask_select == BKM_MASK_NONE) ? BKM_AMASK_ALL :
                        (block_mask_select == BKM_MASK_2K)   ? BKM_AMASK_2K :
                        (block_mask_select == BKM_MASK_8K)   ? BKM_AMASK_8K : BKM_AMASK_32K;
   // Low two bits go to the size/overlap logic instead.
   assign addr_amask   = block_amask & BKM_AMASK_EXT;
   assign block_equal  = ((cyc_addr ^ target_ff) & addr_amask) == 32'h0000_0000;
   assign block_masked = (block_mask_select != BKM_MASK_NONE);
   assign addr_ok      = (block_masked && outside_block_match) ? !block_equal : block_equal;

   // ****************************************************************
   // Size and low-offset check
   // ****************************************************************
   wire logic overlap_hit;
   wire logic exact_hit;
   wire logic size_masked;
   wire logic low_ok;
   wire logic low_checked;

   bkm_overlap u_overlap
   (
      .target_low  (target_ff[1:0]),
      .access_low  (low_address_bits),
      .access_size (cyc_size),
      .hit         (overlap_hit)
   );

   assign size_masked = size_compare_mask || compare_source_select;
   // Exact mode: offset and size both equal the programmed ones.
   assign exact_hit   = (low_address_bits == target_ff[1:0]) && (cyc_size == target_size_code);
   // Low bits count only with no block mask and the internal source.
   assign low_checked = !block_masked && !compare_source_select;
   assign low_ok      = !low_checked ? 1'b1 :
                        size_masked  ? overlap_hit : exact_hit;

   // ****************************************************************
   // Direction and space
   // ****************************************************************
   wire logic dir_ok;
   wire logic space_ok;

   assign dir_ok = (direction_select == BKM_DIR_READ)  ? cyc_read :
                   (direction_select == BKM_DIR_WRITE) ? !cyc_read :
                   (direction_select == BKM_DIR_BOTH);

   bkm_space_check u_space
   (
      .space_exclude_bits  (space_exclude_bits),
      .function_code_lines (cyc_fc),
      .allowed             (space_ok)
   );

   // ****************************************************************
   // Match decision and outputs
   // ****************************************************************
   wire logic match;
   wire logic to_external;
   wire logic nxt_break_int;
   wire logic nxt_break_ext;
   wire logic nxt_bus_error;

   assign match = ctl_valid && cyc_valid && addr_ok && low_ok && dir_ok && space_ok;
   // Internal-to-internal DMA on the external source still breaks the internal core.
   assign to_external   = compare_source_select && !int_dma_internal;
   assign nxt_break_int = match && !to_external;
   assign nxt_break_ext = match && to_external;
   assign nxt_bus_error      = ack_cycle_support && int_break_signal_ack_cycle;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         break_signal     <= 1'b0;
         break_signal_out <= 1'b0;
         bus_error        <= 1'b0;
      end
      else
      begin
         break_signal     <= nxt_break_int;
         break_signal_out <= nxt_break_ext;
         bus_error        <= nxt_bus_error;
      end
   end

   // ****************************************************************
   // Status
   // ****************************************************************
   // Live view of the last cycle's decision terms for debug software.
   assign nxt_status = {1'b0, nxt_bus_error, to_external, space_ok, dir_ok, low_ok, addr_ok, match};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         status_ff <= 8'h00;
      end
      else
      begin
         status_ff <= nxt_status;
      end
   end
endmodule

// ### pkg/bkm_pkg.sv
// Package for the bus breakpoint matcher: register map, field positions and encodings.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package bkm_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0]  BKM_ADDR_TARGET  = 8'h00;
   localparam logic [7:0]  BKM_ADDR_CONTROL = 8'h04;
   localparam logic [7:0]  BKM_ADDR_STATUS  = 8'h08;
   localparam logic [31:0] BKM_CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] BKM_TARGET_RESET = 32'h0000_0000;
   localparam logic [31:0] BKM_CTRL_WMASK   = 32'h000f_ffff;

   // ****************************************************************
   // Control field positions
   // ****************************************************************
   localparam int BKM_F_VALID   = 0;
   localparam int BKM_F_SPACE_L = 1;
   localparam int BKM_F_SPACE_H = 9;
   localparam int BKM_F_MASK_L  = 10;
   localparam int BKM_F_MASK_H  = 11;
   localparam int BKM_F_NEG     = 12;
   localparam int BKM_F_SIZE_L  = 13;
   localparam int BKM_F_SIZE_H  = 14;
   localparam int BKM_F_SIZE_COMPARE_MASK    = 15;
   localparam int BKM_F_DIR_L   = 16;
   localparam int BKM_F_DIR_H   = 17;
   localparam int BKM_F_SRC     = 18;
   localparam int BKM_F_ACK     = 19;
   localparam int BKM_DMA_SPACE = 8;

   // ****************************************************************
   // Encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      BKM_DIR_READ  = 2'b00,
      BKM_DIR_WRITE = 2'b01,
      BKM_DIR_BOTH  = 2'b10,
      BKM_DIR_RSVD  = 2'b11
   } bkm_dir_t;

   typedef enum logic [1:0] {
      BKM_SZ_LONG  = 2'b00,
      BKM_SZ_BYTE  = 2'b01,
      BKM_SZ_WORD  = 2'b10,
      BKM_SZ_THREE = 2'b11
   } bkm_size_t;

   localparam logic [1:0]  BKM_MASK_NONE = 2'b00;
   localparam logic [1:0]  BKM_MASK_2K   = 2'b01;
   localparam logic [1:0]  BKM_MASK_8K   = 2'b10;
   localparam logic [31:0] BKM_AMASK_ALL = 32'hffff_ffff;
   localparam logic [31:0] BKM_AMASK_2K  = 32'hffff_f800;
   localparam logic [31:0] BKM_AMASK_8K  = 32'hffff_e000;
   localparam logic [31:0] BKM_AMASK_32K = 32'hffff_8000;
   localparam logic [31:0] BKM_AMASK_EXT = 32'hffff_fffc;
   localparam logic [31:0] BKM_AMASK_LOW = 32'h0000_0003;
   localparam logic [1:0]  BKM_LOW_ODD_TARGET = 2'b01;
   localparam logic [1:0]  BKM_HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0]  BKM_HSIZE_WORD    = 3'b010;
endpackage

// ### rtl/bkm_overlap.sv
// Overlap decoder: does an access of a given size and offset touch the target byte.
// Assumes sizes coded as long, byte, word and three bytes, big-endian byte lanes from the access offset.
`timescale 1ns/1ps
module bkm_overlap
(
   input  wire logic [1:0] target_low,
   input  wire logic [1:0] access_low,
   input  wire logic [1:0] access_size,
   output wire logic       hit
);
   import bkm_pkg::*;

   // An access covers bytes from its offset up to offset plus length minus one.
   wire logic [2:0] access_len;
   wire logic [2:0] last_byte;

   assign access_len = (access_size == BKM_SZ_BYTE)  ? 3'h1 :
                       (access_size == BKM_SZ_WORD)  ? 3'h2 :
                       (access_size == BKM_SZ_THREE) ? 3'h3 : 3'h4;
   assign last_byte  = 3'({1'b0, access_low} + access_len - 3'h1);
   wire logic span_hit;
   assign span_hit = (target_low >= access_low) && ({1'b0, target_low} <= last_byte);
   // A target at 01 also fires for any access at 10 or 11, so this case is not pure overlap.
   assign hit = span_hit || ((target_low == BKM_LOW_ODD_TARGET) && access_low[1]);
endmodule

// ### rtl/bkm_space_check.sv
// Address-space filter: one exclude bit per function-code space.
// Assumes a four-bit function code; all codes with the top bit set share the DMA bit.
`timescale 1ns/1ps
module bkm_space_check
(
   input  wire logic [8:0] space_exclude_bits,
   input  wire logic [3:0] function_code_lines,
   output wire logic       allowed
);
   import bkm_pkg::*;

   wire logic [8:0] space_hit;

   genvar gi;
   generate
      for (gi = 0; gi < BKM_DMA_SPACE; gi++)
      begin : g_space
         assign space_hit[gi] = (function_code_lines == 4'(gi)) && space_exclude_bits[gi];
      end
   endgenerate
   assign space_hit[BKM_DMA_SPACE] = function_code_lines[3] && space_exclude_bits[BKM_DMA_SPACE];
   assign allowed = ~|space_hit;
endmodule

// ### dv/bkm_matcher_assertions.sv
// Checker for the breakpoint matcher; it sees only the top ports.
// Assumes one hclk domain and that hready is the slave's own hreadyout.
`timescale 1ns/1ps
module bkm_matcher_assertions
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic        int_cycle_valid,
   input wire logic [31:0] int_addr,
   input wire logic        int_read,
   input wire logic [3:0]  int_function_code,
   input wire logic        int_dma_internal,
   input wire logic        int_break_signal_ack_cycle,
   input wire logic        ext_cycle_valid,
   input wire logic        ext_burst_beat,
   input wire logic        break_signal,
   input wire logic        break_signal_out,
   input wire logic        bus_error
);
   import bkm_pkg::*;
   // ****************************************************************
   // Shadow of the programmed registers
   // ****************************************************************
   logic        wr_pend_ff;
   logic [7:0]  wr_addr_ff;
   logic [19:0] ctl_ff;
   logic [31:0] tgt_ff;
   wire  [1:0]  dir = ctl_ff[BKM_F_DIR_H:BKM_F_DIR_L];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         ctl_ff     <= 20'h0_0000;
         tgt_ff     <= 32'h0000_0000;
      end
      else
      begin
         if (wr_pend_ff && wr_addr_ff == BKM_ADDR_CONTROL)
            ctl_ff <= hwdata[19:0];
         if (wr_pend_ff && wr_addr_ff == BKM_ADDR_TARGET)
            tgt_ff <= hwdata;
         wr_pend_ff <= hsel && hready && htrans[1] && hwrite;
         wr_addr_ff <= haddr;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_valid_gate: assert property ((break_signal || break_signal_out) |-> ctl_ff[BKM_F_VALID])
      else $error("break raised while valid is clear");
   a_int_cause: assert property (break_signal |-> $past(ctl_ff[BKM_F_SRC] ?
      (ext_cycle_valid && int_dma_internal) : int_cycle_valid))
      else $error("internal break without a cause");
   a_ext_cause: assert property (break_signal_out |-> $past(ctl_ff[BKM_F_SRC] && ext_cycle_valid
      && !ext_burst_beat && !int_dma_internal))
      else $error("external break without a cause");
   a_ack_bus_error: assert property (int_cycle_valid && int_break_signal_ack_cycle && ctl_ff[BKM_F_ACK] |=> bus_error)
      else $error("bus error missing on ack cycle");
   a_bus_error_cause: assert property (bus_error |-> $past(int_break_signal_ack_cycle && ctl_ff[BKM_F_ACK]))
      else $error("bus error without ack cycle");
   a_dir_filter: assert property (int_cycle_valid && !ctl_ff[BKM_F_SRC] && ((dir == BKM_DIR_READ && !int_read)
      || (dir == BKM_DIR_WRITE && int_read) || dir == BKM_DIR_RSVD) |=> !break_signal)
      else $error("break on excluded direction");
   a_space_dma: assert property (int_cycle_valid && !ctl_ff[BKM_F_SRC] && ctl_ff[BKM_F_SPACE_H]
      && int_function_code[3] |=> !break_signal)
      else $error("break in excluded dma space");
   a_exact_addr: assert property (int_cycle_valid && !ctl_ff[BKM_F_SRC] && ctl_ff[11:10] == BKM_MASK_NONE
      && int_addr[31:2] != tgt_ff[31:2] |=> !break_signal)
      else $error("break on other address");

   c_int_break: cover property (break_signal);
   c_ext_break: cover property (break_signal_out);
   c_bus_error: cover property (bus_error);
endmodule

// ### dv/bkm_cycle_model.sv
// Model of the monitored bus masters: presents one bus cycle per call.
// Assumes a single caller; released address and function-code lines carry inverted values.
`timescale 1ns/1ps
module bkm_cycle_model
(
   input  wire logic  hclk,
   output logic       int_cycle_valid,
   output logic [31:0] int_addr,
   output logic       int_read,
   output logic [1:0] int_size,
   output logic [3:0] int_function_code,
   output logic       int_dma_internal,
   output logic       int_break_signal_ack_cycle,
   output logic       ext_cycle_valid,
   output logic [31:0] ext_addr,
   output logic       ext_read,
   output logic [1:0] ext_size,
   output logic [3:0] ext_function_code,
   output logic       ext_burst_beat
);
   initial
   begin
      {int_cycle_valid, int_addr, int_read, int_size, int_function_code} = 40'h0;
      {int_dma_internal, int_break_signal_ack_cycle, ext_cycle_valid, ext_burst_beat} = 4'h0;
      {ext_addr, ext_read, ext_size, ext_function_code} = 39'h0;
   end

   task automatic cycle(input logic ext, input logic [31:0] a, input logic rd, input logic [1:0] sz,
                        input logic [3:0] fc, input logic dma, beat, ack);
      @(posedge hclk);
      int_cycle_valid    <= !ext;
      ext_cycle_valid    <= ext;
      {int_addr, ext_addr} <= {a, a};
      {int_read, ext_read, int_size, ext_size} <= {rd, rd, sz, sz};
      {int_function_code, ext_function_code} <= {fc, fc};
      {int_dma_internal, ext_burst_beat, int_break_signal_ack_cycle} <= {dma, beat, ack};
      @(posedge hclk);
      // A released bus must not keep showing the last cycle's address.
      {int_cycle_valid, ext_cycle_valid} <= 2'h0;
      {int_addr, ext_addr} <= {~a, ~a};
      {int_function_code, ext_function_code} <= {~fc, ~fc};
      {int_dma_internal, ext_burst_beat, int_break_signal_ack_cycle} <= 3'h0;
   endtask
endmodule

// ### dv/bus_breakpoint_matcher_bench.sv
// Self-checking bench for the breakpoint matcher.
// Assumes a single AHB-Lite slave, so hready is the slave's hreadyout.
`timescale 1ns/1ps
module bus_breakpoint_matcher_bench;
   import bkm_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire  logic  hready, int_cycle_valid, int_read, int_dma_internal, int_break_signal_ack_cycle;
   wire  logic  ext_cycle_valid, ext_read, ext_burst_beat, break_signal, break_signal_out, bus_error;
   wire  logic [31:0] int_addr, ext_addr;
   wire  logic [1:0]  int_size, ext_size;
   wire  logic [3:0]  int_function_code, ext_function_code;
   logic [31:0] hrdata;
   int          n_errors = 0;
   int          cmp_count = 0;
   // Entries pack target offset, access offset, access size and expected hit.
   localparam logic [6:0] OVL [18] = '{7'h41, 7'h44, 7'h47, 7'h4a, 7'h4d, 7'h53, 7'h58, 7'h61, 7'h66,
                                       7'h6f, 7'h75, 7'h72, 7'h03, 7'h08, 7'h25, 7'h22, 7'h29, 7'h31};
   localparam logic [7:0] TA = BKM_ADDR_TARGET;
   localparam logic [7:0] CR = BKM_ADDR_CONTROL;

   bkm_matcher bkm_matcher_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
      .hrdata, .hreadyout(hready), .hresp(), .int_cycle_valid, .int_addr, .int_read, .int_size,
      .int_function_code, .int_dma_internal, .int_break_signal_ack_cycle, .ext_cycle_valid, .ext_addr, .ext_read,
      .ext_size, .ext_function_code, .ext_burst_beat, .break_signal, .break_signal_out, .bus_error);
   bkm_cycle_model bkm_cycle_model_inst (.hclk, .int_cycle_valid, .int_addr, .int_read, .int_size,
      .int_function_code, .int_dma_internal, .int_break_signal_ack_cycle, .ext_cycle_valid, .ext_addr, .ext_read,
      .ext_size, .ext_function_code, .ext_burst_beat);

   always #25 hclk = ~hclk;

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, a, BKM_HTRANS_NONSEQ, w, BKM_HSIZE_WORD};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      {hsel, htrans} <= 3'h0;
      hwdata <= w ? d : 32'h0;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk("register", q, exp);
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] dir, sz, input logic sm = 1'b0, input logic [1:0] ma = 2'h0,
                                       input logic neg = 1'b0, src = 1'b0, input logic [8:0] sp = 9'h0);
      return {12'h0, 1'b0, src, dir, sm, sz, neg, ma, sp, 1'b1};
   endfunction

   // Flags are dma, burst beat, ack cycle; the result is internal break, external break, bus error.
   task automatic hit(input logic ext, input logic [31:0] a, input logic rd, input logic [1:0] sz,
                      input logic [2:0] exp, input logic [3:0] fc = 4'h5, input logic [2:0] fl = 3'h0);
      bkm_cycle_model_inst.cycle(ext, a, rd, sz, fc, fl[2], fl[1], fl[0]);
      #1;
      chk("break outputs", {29'h0, break_signal, break_signal_out, bus_error}, {29'h0, exp});
   endtask

   task automatic t_regs;
      rdc(TA, 32'h0);
      rdc(CR, 32'h0);
      wr(CR, 32'hffff_ffff);
      rdc(CR, 32'h000f_ffff);
      wr(8'h0c, 32'h1234_5678);
      rdc(8'h0c, 32'h0);
      wr(TA, 32'hdead_beef);
      rdc(TA, 32'hdead_beef);
      wr(TA, 32'h1000);
      wr(CR, ctl(BKM_DIR_BOTH, BKM_SZ_LONG, 1'b1) & ~32'h1);
      hit(1'b0, 32'h1000, 1'b1, BKM_SZ_LONG, 3'h0);
   endtask

   task automatic t_dir_size;
      for (int d = 0; d < 4; d++)
      begin
         wr(CR, ctl(d[1:0], BKM_SZ_LONG, 1'b1));
         hit(1'b0, 32'h1000, 1'b1, BKM_SZ_LONG, {d == 0 || d == 2, 2'h0});
         hit(1'b0, 32'h1000, 1'b0, BKM_SZ_LONG, {d == 1 || d == 2, 2'h0});
      end
      for (int s = 0; s < 4; s++)
      begin
         wr(CR, ctl(BKM_DIR_BOTH, s[1:0]));
         for (int k = 0; k < 4; k++)
            hit(1'b0, 32'h1000, 1'b1, k[1:0], {s == k, 2'h0});
      end
      wr(TA, 32'h1002);
      wr(CR, ctl(BKM_DIR_BOTH, BKM_SZ_WORD));
      hit(1'b0, 32'h1002, 1'b1, BKM_SZ_WORD, 3'h4);
      hit(1'b0, 32'h1000, 1'b1, BKM_SZ_LONG, 3'h0);
      hit(1'b0, 32'h1006, 1'b1, BKM_SZ_WORD, 3'h0);
      wr(CR, ctl(BKM_DIR_BOTH, BKM_SZ_BYTE, 1'b1));
      foreach (OVL[i])
      begin
         wr(TA, {30'h400, OVL[i][6:5]});
         hit(1'b0, {30'h400, OVL[i][4:3]}, 1'b1, OVL[i][2:1], {OVL[i][0], 2'h0});
      end
   endtask

   task automatic t_block_space;
      logic [31:0] lim;
      wr(TA, 32'h1000_0000);
      for (int m = 1; m < 4; m++)
      begin
         lim = (m == 1) ? 32'h7ff : (m == 2) ? 32'h1fff : 32'h7fff;
         wr(CR, ctl(BKM_DIR_BOTH, BKM_SZ_LONG, 1'b0, m[1:0]));
         hit(1'b0, 32'h1000_0000 | lim, 1'b1, BKM_SZ_BYTE, 3'h4);
         hit(1'b0, 32'h1000_0001 + lim, 1'b1, BKM_SZ_BYTE, 3'h0);
         wr(CR, ctl(BKM_DIR_READ, BKM_SZ_LONG, 1'b0, m[1:0], 1'b1));
         hit(1'b0, 32'h1000_0001 + lim, 1'b1, BKM_SZ_BYTE, 3'h4);
         hit(1'b0, 32'h1000_0001 + lim, 1'b0, BKM_SZ_BYTE, 3'h0);
         hit(1'b0, 32'h1000_0004, 1'b1, BKM_SZ_BYTE, 3'h0);
      end
      for (int i = 0; i < 9; i++)
      begin
         wr(CR, ctl(BKM_DIR_BOTH, BKM_SZ_LONG, 1'b0, 2'h1, 1'b0, 1'b0, 9'h1 << i));
         hit(1'b0, 32'h1000_0000, 1'b1, BKM_SZ_LONG, 3'h0, (i < 8) ? i[3:0] : 4'hc);
         hit(1'b0, 32'h1000_0000, 1'b1, BKM_SZ_LONG, 3'h4, (i == 0) ? 4'h1 : 4'h0);
      end
   endtask

   task automatic t_ext_ack;
      wr(TA, 32'h2000_0000);
      wr(CR, ctl(BKM_DIR_BOTH, BKM_SZ_WORD, 1'b0, 2'h0, 1'b0, 1'b1));
      hit(1'b1, 32'h2000_0003, 1'b1, BKM_SZ_BYTE, 3'h2);
      hit(1'b1, 32'h2000_0004, 1'b1, BKM_SZ_WORD, 3'h0);
      hit(1'b1, 32'h2000_0000, 1'b1, BKM_SZ_WORD, 3'h0, 4'h5, 3'h2);
      hit(1'b1, 32'h2000_0000, 1'b1, BKM_SZ_WORD, 3'h4, 4'h5, 3'h4);
      hit(1'b0, 32'h2000_0000, 1'b1, BKM_SZ_WORD, 3'h0);
      wr(CR, 32'h1 << BKM_F_ACK);
      hit(1'b0, 32'h0, 1'b1, BKM_SZ_LONG, 3'h1, 4'h7, 3'h1);
      wr(CR, 32'h0);
      hit(1'b0, 32'h0, 1'b1, BKM_SZ_LONG, 3'h0, 4'h7, 3'h1);
   endtask

   task automatic close_out;
      $display("%0d comparisons, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_dir_size;
      t_block_space;
      t_ext_ack;
      close_out;
   end

   initial
   begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      close_out;
   end
endmodule

bind bkm_matcher bkm_matcher_assertions bkm_matcher_assertions_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hwdata, .int_cycle_valid, .int_addr, .int_read, .int_function_code, .int_dma_internal,
   .int_break_signal_ack_cycle, .ext_cycle_valid, .ext_burst_beat, .break_signal, .break_signal_out, .bus_error);
